//--- include/ew_pkg.sv
package ew_pkg;

  typedef enum logic [2:0] {
    EW_IDLE,
    EW_DEVADDR,
    EW_ADDRHI,
    EW_ADDRLO,
    EW_WRDATA,
    EW_RDDATA,
    EW_IGNORE
  } ew_state_t;

endpackage

//--- include/ew_regs.svh
`ifndef EW_REGS_SVH
`define EW_REGS_SVH

// System clock and self-timed write bound
`define EW_CLK_MHZ 200
`define EW_TWR_MS 10
`define EW_TWR_CYCLES (`EW_TWR_MS * 1000 * `EW_CLK_MHZ)

// Array geometry
`define EW_ADDR_W 18
`define EW_MEM_BYTES 262144
`define EW_PAGE_BYTES 256

// Highest serial clock rate the oversampling is sized for
`define EW_SCL_MAX_KHZ 1000

// Serial framing
`define EW_DEV_TYPE 4'ha
`define EW_LAST_DATA_BIT 4'h7
`define EW_ACK_BIT 4'h8

// Write data buffer
`define EW_FIFO_DEPTH 2

`endif

//--- sim/ew_host_model.sv
module ew_host_model (
  input wire logic lnkClk,
  input wire logic sdaLine,
  output logic sclClk,
  output logic hostLow
);
  timeunit 1ns;
  timeprecision 1ps;
  // 34 link ticks a half period keeps the serial clock just under 1 MHz
  localparam int HALF = 34;
  initial begin
    sclClk = 1'b1;
    hostLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lnkClk);
  endtask
  task automatic bitOut(input logic b);
    tick(HALF / 2);
    hostLow <= ~b;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF);
    sclClk <= 1'b0;
  endtask
  task automatic bitIn(output logic b);
    tick(HALF / 2);
    hostLow <= 1'b0;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF / 2);
    b = sdaLine;
    tick(HALF / 2);
    sclClk <= 1'b0;
  endtask
  task automatic startCond();
    tick(HALF / 2);
    hostLow <= 1'b0;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF);
    hostLow <= 1'b1;
    tick(HALF);
    sclClk <= 1'b0;
  endtask
  task automatic stopCond();
    tick(HALF / 2);
    hostLow <= 1'b1;
    tick(HALF / 2);
    sclClk <= 1'b1;
    tick(HALF);
    hostLow <= 1'b0;
    tick(HALF * 2);
  endtask
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(b);
    ack = ~b;
  endtask
  // A released line reads high through the pull-up, so a final release is a refusal
  task automatic readByte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(last);
  endtask
endmodule

//--- sim/testbench.sv
`include "ew_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WRC = 2500;
  logic clk_sys = 1'b0;
  logic lnkClk = 1'b0;
  logic rstn = 1'b0;
  logic addressSelectStrap = 1'b0;
  logic writeProtect = 1'b0;
  logic sdaOut, sdaOe, writeBusy, sclClk, hostLow;
  logic [7:0] mem [logic [17:0]];
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int busyLen = 0;
  int lastBusy = 0;
  int busyRuns = 0;
  // Pull-up: the line is high unless a party pulls it low
  wire logic sdaLine = ~hostLow & (~sdaOe | sdaOut);

  always #2.5 clk_sys = ~clk_sys;
  initial begin
    #1.1;
    forever #7.5 lnkClk = ~lnkClk;
  end

  ew_eeprom_slave #(.WRITE_CYCLES(WRC)) ew_eeprom_slave_i (
    .clk_sys(clk_sys), .rstn(rstn), .sclClk(sclClk), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addressSelectStrap(addressSelectStrap), .writeProtect(writeProtect),
    .writeBusy(writeBusy));
  ew_host_model ew_host_model_i (
    .lnkClk(lnkClk), .sdaLine(sdaLine), .sclClk(sclClk), .hostLow(hostLow));

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    busyLen <= (writeBusy === 1'b1) ? busyLen + 1 : 0;
    if (writeBusy !== 1'b1 && busyLen != 0) begin
      lastBusy <= busyLen;
      busyRuns <= busyRuns + 1;
    end
    if (cycles == 110000) begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write data wraps inside its 256-byte page instead of spilling over
  function automatic logic [17:0] pageSlot(input logic [17:0] a, input int i);
    return {a[17:8], 8'(a[7:0] + i)};
  endfunction

  task automatic sendHdr(input logic s, input logic [17:0] a, input logic rd, output logic ack);
    ew_host_model_i.writeByte({`EW_DEV_TYPE, s, a[17:16], rd}, ack);
  endtask

  task automatic sendAddr(input logic [17:0] a);
    logic ack;
    sendHdr(addressSelectStrap, a, 1'b0, ack);
    check("select ack", 1, ack);
    ew_host_model_i.writeByte(a[15:8], ack);
    check("high address ack", 1, ack);
    ew_host_model_i.writeByte(a[7:0], ack);
    check("low address ack", 1, ack);
  endtask

  task automatic doWrite(input logic [17:0] a, input int n, input logic prot);
    logic ack;
    logic [7:0] d;
    ew_host_model_i.startCond();
    sendAddr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ew_host_model_i.writeByte(d, ack);
      check("data ack", {31'h0, ~prot}, ack);
      if (prot) break;
      mem[pageSlot(a, i)] = d;
    end
    ew_host_model_i.stopCond();
  endtask

  // Polls straight after the stop, while the self-timed write must still run
  task automatic busyPhase(input logic expBusy);
    logic ack;
    int runs;
    runs = busyRuns;
    ew_host_model_i.startCond();
    sendHdr(addressSelectStrap, 18'h0, 1'b0, ack);
    ew_host_model_i.stopCond();
    check("select while writing", {31'h0, ~expBusy}, ack);
    for (int i = 0; i < 3000 && writeBusy !== 1'b0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    check("write cycles run", {31'h0, expBusy}, busyRuns - runs);
    if (expBusy) check("write cycle length", WRC, lastBusy);
  endtask

  task automatic doRead(input logic [17:0] a, input int n);
    logic ack;
    logic [7:0] d;
    ew_host_model_i.startCond();
    sendAddr(a);
    ew_host_model_i.startCond();
    sendHdr(addressSelectStrap, a, 1'b1, ack);
    check("read select ack", 1, ack);
    for (int i = 0; i < n; i++) begin
      ew_host_model_i.readByte(i == n - 1, d);
      check("read data", mem[18'(a + i)], d);
    end
    ew_host_model_i.stopCond();
  endtask

  initial begin
    logic [17:0] a;
    logic ack;
    int n;
    void'($urandom(26954));
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("busy after reset", 0, writeBusy);
    // Strap low stands for a floating pin, which must read as low
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      addressSelectStrap <= s[0];
      repeat (4) @(posedge clk_sys);
      for (int m = 0; m < 2; m++) begin
        ew_host_model_i.startCond();
        sendHdr(s[0] ^ m[0], 18'h0, 1'b0, ack);
        ew_host_model_i.stopCond();
        check("strap select", {31'h0, ~m[0]}, ack);
      end
    end
    $display("strap test done");
    for (int t = 0; t < 2; t++) begin
      a = (t == 0) ? {10'($urandom), 8'($urandom_range(239))} : {10'($urandom), 8'hff};
      n = (t == 0) ? 1 : 2 + $urandom_range(2);
      doWrite(a, n, 1'b0);
      busyPhase(1'b1);
      doRead(a, 1);
      if (n > 1) doRead({a[17:8], 8'h00}, n - 1);
      $display("write test %0d done", t);
    end
    @(posedge clk_sys);
    writeProtect <= 1'b1;
    repeat (4) @(posedge clk_sys);
    doWrite(a, 1, 1'b1);
    busyPhase(1'b0);
    writeProtect <= 1'b0;
    doRead(a, 1);
    $display("protect test done");
    results();
  end
endmodule

//--- src/ew_eeprom_slave.sv
`include "ew_regs.svh"

module ew_eeprom_slave
  import ew_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `EW_TWR_CYCLES,
  parameter int unsigned ADDR_W = `EW_ADDR_W,
  parameter int unsigned PAGE_BYTES = `EW_PAGE_BYTES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addressSelectStrap,
  input wire logic writeProtect,
  output logic writeBusy
);

  localparam int unsigned OW = $clog2(PAGE_BYTES);
  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);
  localparam int unsigned MEM_BYTES = `EW_MEM_BYTES;
  localparam int unsigned NSYNC = 4;
  // Bus lines idle high, straps default low
  localparam logic [NSYNC-1:0] SYNC_INIT = 4'h3;

  function automatic logic devMatch(input logic [7:0] b, input logic strap);
    return (b[7:4] == `EW_DEV_TYPE) && (b[3] == strap);
  endfunction

  // Link domain: shift register on the serial clock, open-drain driver
  logic [7:0] shiftIn;
  logic driveLow;

  always_ff @(posedge sclClk or negedge rstn) begin
    if (!rstn) begin
      shiftIn <= 8'h00;
    end else begin
      shiftIn <= {shiftIn[6:0], sdaIn};
    end
  end

  // Level settles just after the rise and holds, so the fall samples it stable
  always_ff @(negedge sclClk or negedge rstn) begin
    if (!rstn) begin
      sdaOe <= 1'b0;
    end else begin
      sdaOe <= driveLow;
    end
  end

  assign sdaOut = 1'b0;

  // System domain: pin synchronisers
  logic [NSYNC-1:0] pinRaw, pinMeta, pinSync;
  assign pinRaw = {writeProtect, addressSelectStrap, sdaIn, sclClk};

  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        pinMeta[i] <= SYNC_INIT[i];
        pinSync[i] <= SYNC_INIT[i];
      end else begin
        pinMeta[i] <= pinRaw[i];
        pinSync[i] <= pinMeta[i];
      end
    end
  end

  wire sclS = pinSync[0];
  wire sdaS = pinSync[1];
  wire strapS = pinSync[2];
  wire wpS = pinSync[3];
  logic sclPrev, sdaPrev;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // 200 clocks per microsecond leave 100 samples in the high phase of a 1 MHz serial clock
  wire sclRise = sclS & ~sclPrev;
  wire startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopCond = sclS & sclPrev & ~sdaPrev & sdaS;

  ew_state_t state;
  logic [3:0] bitCnt;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-OW-1:0] pageBase;
  logic [7:0] rdShift;
  logic rdFirst;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pageData [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask;
  logic [OW:0] commitIdx;
  logic [TW-1:0] writeTimer;

  wire byteDone = sclRise & (bitCnt == `EW_LAST_DATA_BIT);
  wire ackClk = sclRise & (bitCnt == `EW_ACK_BIT);
  wire selectOk = devMatch(shiftIn, strapS) & ~writeBusy;
  wire clearPage = byteDone & (state == EW_DEVADDR) & selectOk & ~shiftIn[0];

  // Write data path through the two-entry buffer
  logic fifoInReady;
  logic fifoOutValid;
  logic [OW+7:0] fifoOut;
  wire wrAccept = fifoInReady & ~wpS;
  wire fifoInValid = byteDone & (state == EW_WRDATA) & wrAccept;
  wire fifoOutReady = ~writeBusy;
  wire drain = fifoOutValid & fifoOutReady;

  ew_pipe_buf #(
    .WIDTH(OW + 8),
    .DEPTH(`EW_FIFO_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inData({addr[OW-1:0], shiftIn}),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOut),
    .outReady(fifoOutReady)
  );

  wire startWrite = stopCond & (state == EW_WRDATA) & (|pageMask) & ~wpS;
  wire commitWe = writeBusy & ~commitIdx[OW] & pageMask[commitIdx[OW-1:0]];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= EW_IDLE;
      bitCnt <= 4'h0;
      addr <= '0;
      pageBase <= '0;
      rdShift <= 8'h00;
      rdFirst <= 1'b0;
      driveLow <= 1'b0;
    end else if (startCond) begin
      state <= EW_DEVADDR;
      bitCnt <= 4'h0;
      driveLow <= 1'b0;
    end else if (stopCond) begin
      state <= EW_IDLE;
      bitCnt <= 4'h0;
      driveLow <= 1'b0;
    end else if (sclRise && state != EW_IDLE) begin
      bitCnt <= (bitCnt == `EW_ACK_BIT) ? 4'h0 : bitCnt + 4'h1;
      driveLow <= 1'b0;
      unique case (state)
        EW_DEVADDR: begin
          if (byteDone && selectOk) begin
            driveLow <= 1'b1;
            addr[ADDR_W-1:ADDR_W-2] <= shiftIn[2:1];
            rdFirst <= 1'b1;
            state <= shiftIn[0] ? EW_RDDATA : EW_ADDRHI;
          end else if (byteDone) begin
            state <= EW_IGNORE;
          end
        end
        EW_ADDRHI: begin
          if (byteDone) begin
            driveLow <= 1'b1;
            addr[15:8] <= shiftIn;
            state <= EW_ADDRLO;
          end
        end
        EW_ADDRLO: begin
          if (byteDone) begin
            driveLow <= 1'b1;
            addr[7:0] <= shiftIn;
            pageBase <= addr[ADDR_W-1:OW];
            state <= EW_WRDATA;
          end
        end
        EW_WRDATA: begin
          if (byteDone && wrAccept) begin
            driveLow <= 1'b1;
            addr[OW-1:0] <= addr[OW-1:0] + 1'b1;
          end else if (byteDone) begin
            state <= EW_IGNORE;
          end
        end
        EW_RDDATA: begin
          if (ackClk) begin
            rdFirst <= 1'b0;
            if (rdFirst || !shiftIn[0]) begin
              rdShift <= mem[addr];
              driveLow <= ~mem[addr][7];
            end else begin
              state <= EW_IGNORE;
            end
          end else if (byteDone) begin
            addr <= addr + 1'b1;
          end else begin
            driveLow <= ~rdShift[6];
            rdShift <= {rdShift[6:0], 1'b0};
          end
        end
        EW_IGNORE, EW_IDLE: begin
        end
      endcase
    end
  end

  // Page buffer and array have no reset; the mask alone marks valid bytes
  always_ff @(posedge clk_sys) begin
    if (drain) begin
      pageData[fifoOut[OW+7:8]] <= fifoOut[7:0];
    end
    if (commitWe) begin
      mem[{pageBase, commitIdx[OW-1:0]}] <= pageData[commitIdx[OW-1:0]];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pageMask <= '0;
    end else if (clearPage) begin
      pageMask <= '0;
    end else if (drain) begin
      pageMask[fifoOut[OW+7:8]] <= 1'b1;
    end
  end

  // Commit walks the page once; busy stays for the full write time so that
  // the host sees a fixed, bounded window of refused selects
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      writeBusy <= 1'b0;
      writeTimer <= '0;
      commitIdx <= '0;
    end else if (startWrite) begin
      writeBusy <= 1'b1;
      writeTimer <= TW'(WRITE_CYCLES - 1);
      commitIdx <= '0;
    end else if (writeBusy) begin
      if (!commitIdx[OW]) begin
        commitIdx <= commitIdx + 1'b1;
      end
      if (writeTimer == '0) begin
        writeBusy <= 1'b0;
      end else begin
        writeTimer <= writeTimer - 1'b1;
      end
    end
  end

  // Checks
  logic [TW:0] busyLen;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busyLen <= '0;
    end else if (startWrite) begin
      busyLen <= '0;
    end else if (writeBusy) begin
      busyLen <= busyLen + 1'b1;
    end
  end

  sequence s_selMiss;
    byteDone && state == EW_DEVADDR && !devMatch(shiftIn, strapS);
  endsequence
  sequence s_rdByteEnd;
    byteDone && state == EW_RDDATA;
  endsequence
  property p_capture;
    @(posedge sclClk) disable iff (!rstn) 1'b1 |=> shiftIn[0] == $past(sdaIn);
  endproperty
  a_capture: assert property (p_capture) else $error("data bit not taken at rise");
  property p_drive_timing;
    @(posedge clk_sys) disable iff (!rstn)
      $changed(driveLow) |-> $past(sclRise || startCond || stopCond);
  endproperty
  a_drive_timing: assert property (p_drive_timing) else $error("drive level moved mid phase");
  property p_wp_nack;
    @(posedge clk_sys) disable iff (!rstn)
      (byteDone && state == EW_WRDATA && wpS) |=> (state == EW_IGNORE && !driveLow);
  endproperty
  a_wp_nack: assert property (p_wp_nack) else $error("protected write acknowledged");
  property p_wp_no_write;
    @(posedge clk_sys) disable iff (!rstn) $rose(writeBusy) |-> $past(!wpS);
  endproperty
  a_wp_no_write: assert property (p_wp_no_write) else $error("write began while protected");
  property p_strap_mismatch;
    @(posedge clk_sys) disable iff (!rstn) s_selMiss |=> state == EW_IGNORE && !driveLow;
  endproperty
  a_strap_mismatch: assert property (p_strap_mismatch) else $error("foreign select answered");
  property p_strap_reset;
    @(posedge clk_sys) disable iff (!rstn) $rose(rstn) |-> (!strapS && !wpS);
  endproperty
  a_strap_reset: assert property (p_strap_reset) else $error("straps not low after reset");
  property p_page_wrap;
    @(posedge clk_sys) disable iff (!rstn)
      (byteDone && state == EW_WRDATA && wrAccept)
        |=> (addr[ADDR_W-1:OW] == $past(addr[ADDR_W-1:OW])
             && addr[OW-1:0] == $past(addr[OW-1:0]) + 1'b1);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page address left its page");
  property p_twr_bound;
    @(posedge clk_sys) disable iff (!rstn)
      writeBusy |-> busyLen < (TW + 1)'(WRITE_CYCLES);
  endproperty
  a_twr_bound: assert property (p_twr_bound) else $error("write cycle overran");
  property p_commit_done;
    @(posedge clk_sys) disable iff (!rstn) $fell(writeBusy) |-> commitIdx[OW];
  endproperty
  a_commit_done: assert property (p_commit_done) else $error("busy ended before commit");
  property p_read_incr;
    @(posedge clk_sys) disable iff (!rstn) s_rdByteEnd |=> addr == $past(addr) + 1'b1;
  endproperty
  a_read_incr: assert property (p_read_incr) else $error("read pointer did not advance");
  property p_busy_ignore;
    @(posedge clk_sys) disable iff (!rstn)
      (byteDone && state == EW_DEVADDR && writeBusy) |=> (state == EW_IGNORE && !driveLow);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("select taken during write");

endmodule

//--- src/ew_pipe_buf.sv
`include "ew_regs.svh"

module ew_pipe_buf
  import ew_pkg::*;
#(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = `EW_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = (count != FULL);
  assign outValid = (count != '0);
  assign outData = slot[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  property p_no_overflow;
    @(posedge clk_sys) disable iff (!rstn) (count == FULL && !pop) |=> count == FULL;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer lost or gained a word");

endmodule
